// File: core/ctp_pkg.sv
// Package of constants and types for the cell and temperature protector control
//
// Overview of operation
// - Voltage start captures limits, mode, masks
// - One overvoltage, one undervoltage limit shared
// - Inactive voltage channels ignored, masked ones skip undervoltage only
// - Voltage protector runs through sleep until stopped
// - Voltage running status high while operating
// - Overvoltage, undervoltage faults in register pairs
// - Balance done stops balancing in robin mode only, no fault
// - Five-bit hot, three-bit cold limits shared
// - Pin active only with ADC-plus-protector config
// - Ratio below hot limit flags hot fault
// - Ratio above cold limit flags cold fault
// - Missing thermistor reference flags hot and cold on every active pin
// - Temperature mode: stop, robin, self-test, lock
// - Robin steps all pins, fixed timing
// - Robin hot check uses balance hot limit
// - Self-test withholds measurements and detections
// - Lock mode fixes comparators on one pin
// - Temperature start captures limits, mode, configs
// - Temperature protector runs through sleep
// - Temperature running status high while operating
// - Hot and cold faults in separate registers
// - Balance hot pauses balancing, no fault
// - Voltage mode: stop, robin, self-test, lock
// - Below undervoltage or above overvoltage flags
// - Highest cell count implies lower channels active
package ctp_pkg;
    localparam int NUM_CELLS   = 16;              // Cell voltage channels
    localparam int NUM_PINS    = 8;               // Thermistor pins
    localparam int CELL_IDX_W  = 4;               // Cell index width
    localparam int PIN_IDX_W   = 3;               // Pin index width
    localparam int VLIM_W      = 8;               // Voltage limit code width
    localparam int HOT_W       = 5;               // Hot limit field width
    localparam int COLD_W      = 3;               // Cold limit field width
    localparam int BHOT_W      = 5;               // Balance hot limit width
    localparam int COOL_W      = 3;               // Cool-off hysteresis width
    localparam int CONF_W      = 3;               // Per-pin config width
    localparam int HALF_W      = 8;               // Fault register half width
    localparam int SLOT_NS     = 50;              // Dwell per channel in robin
    localparam int CLK_NS      = 50;              // Clock period
    localparam int SLOT_CYC    = (SLOT_NS + CLK_NS - 1) / CLK_NS; // Cycles per slot
    localparam logic [CONF_W-1:0] CONF_ADC_TEMP = 3'h2; // ADC plus protector input
    localparam logic [HALF_W-1:0] FAULT_RST     = 8'h00; // Fault reset value
    // Protector mode codes
    typedef enum logic [1:0] {
        CTP_MODE_STOP  = 2'h0,
        CTP_MODE_ROBIN = 2'h1,
        CTP_MODE_TEST  = 2'h2,
        CTP_MODE_LOCK  = 2'h3
    } ctp_mode_t;
    // One-hot run states
    typedef enum logic [2:0] {
        CTP_ST_IDLE = 3'h1,
        CTP_ST_RUN  = 3'h2,
        CTP_ST_TEST = 3'h4
    } ctp_state_t;
endpackage

// File: core/ctp_chan_scan.sv
// Channel scanner: steps a channel index in fixed slots or holds a locked one
`timescale 1ns/1ns
module ctp_chan_scan #(
    parameter int IDX_W = 4,                      // Index width
    parameter int LAST  = 15                      // Highest index
) (
    input  wire logic             clk_i,          // Clock
    input  wire logic             rst_n_i,        // Async reset, active low
    input  wire logic             run_i,          // Scan enabled
    input  wire logic             lock_i,         // Hold locked channel
    input  wire logic [IDX_W-1:0] lock_sel_i,     // Locked channel
    output logic      [IDX_W-1:0] chan_o,         // Current channel
    output logic                  slot_end_o      // Last cycle of a slot
);
    import ctp_pkg::*;

    logic [IDX_W-1:0] chan_q, chan_d;             // Channel index
    logic [7:0]       tick_q, tick_d;             // Slot cycle counter

    assign slot_end_o = run_i && (tick_q == 8'(SLOT_CYC - 1));
    // Lock shows the locked channel from the very first slot
    assign chan_o     = lock_i ? lock_sel_i : chan_q;

    // Next index: fixed timing whatever channels are active
    always_comb begin
        tick_d = tick_q;
        chan_d = chan_q;
        if (!run_i) begin
            tick_d = 8'h00;
            chan_d = '0;
        end else if (lock_i) begin
            tick_d = slot_end_o ? 8'h00 : tick_q + 8'h01;
            chan_d = lock_sel_i;
        end else if (slot_end_o) begin
            tick_d = 8'h00;
            chan_d = (chan_q == IDX_W'(LAST)) ? '0 : chan_q + 1'b1;
        end else begin
            tick_d = tick_q + 8'h01;
        end
    end

    // Register index and counter
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chan_q <= '0;
            tick_q <= 8'h00;
        end else begin
            chan_q <= chan_d;
            tick_q <= tick_d;
        end
    end

    // Index stays in range
    a_scan_range: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        chan_q <= IDX_W'(LAST)) else $error("Scan index out of range");
endmodule // ctp_chan_scan

// File: core/ctp_protect_ctrl.sv
// Control and status of the cell voltage and thermistor protectors
`timescale 1ns/1ns
module ctp_protect_ctrl (
    input  wire logic                                  clk_i,       // Clock
    input  wire logic                                  rst_n_i,     // Async reset, active low
    // Voltage protector settings
    input  wire logic                                  volt_protect_start_i, // Start pulse
    input  wire logic [1:0]                            volt_protect_mode_i,  // Mode
    input  wire logic [ctp_pkg::VLIM_W-1:0]            overvoltage_limit_i,  // OV limit
    input  wire logic [ctp_pkg::VLIM_W-1:0]            undervoltage_limit_i, // UV limit
    input  wire logic [ctp_pkg::VLIM_W-1:0]            balance_done_limit_i, // Done limit
    input  wire logic [ctp_pkg::CELL_IDX_W-1:0]        highest_cell_field_i, // Top cell
    input  wire logic [ctp_pkg::HALF_W-1:0]            undervolt_mask_low_i, // UV mask 1-8
    input  wire logic [ctp_pkg::HALF_W-1:0]            undervolt_mask_high_i,// UV mask 9-16
    input  wire logic [ctp_pkg::CELL_IDX_W-1:0]        volt_lock_i,          // Locked cell
    // Per-cell voltage codes, flattened
    input  wire logic [ctp_pkg::NUM_CELLS*ctp_pkg::VLIM_W-1:0] cell_volt_i, // Cell codes
    // Temperature protector settings
    input  wire logic                                  temp_protect_start_i, // Start pulse
    input  wire logic [1:0]                            temp_protect_mode_i,  // Mode
    input  wire logic [ctp_pkg::HOT_W-1:0]             hot_limit_field_i,    // Hot limit
    input  wire logic [ctp_pkg::COLD_W-1:0]            cold_limit_field_i,   // Cold limit
    input  wire logic [ctp_pkg::BHOT_W-1:0]            balance_hot_limit_i,  // Balance hot
    input  wire logic [ctp_pkg::COOL_W-1:0]            cool_off_hyst_i,      // Hysteresis
    input  wire logic [ctp_pkg::NUM_PINS*ctp_pkg::CONF_W-1:0] pin_config_i, // Pin configs
    input  wire logic [ctp_pkg::PIN_IDX_W-1:0]         temp_channel_lock_i,  // Locked pin
    input  wire logic                                  thermistor_reference_i, // Ref on
    // Pin ratio codes, 5 bits each, flattened
    input  wire logic [ctp_pkg::NUM_PINS*ctp_pkg::HOT_W-1:0] pin_ratio_i,  // Pin ratios
    input  wire logic                                  shutdown_i,   // Device shutdown
    input  wire logic                                  fault_clear_i,// Clear faults pulse
    // Status
    output logic                                       volt_protect_running_o, // Volt run
    output logic                                       temp_protect_running_o, // Temp run
    output logic [ctp_pkg::HALF_W-1:0]                 overvolt_fault_low_o,   // OV 1-8
    output logic [ctp_pkg::HALF_W-1:0]                 overvolt_fault_high_o,  // OV 9-16
    output logic [ctp_pkg::HALF_W-1:0]                 undervolt_fault_low_o,  // UV 1-8
    output logic [ctp_pkg::HALF_W-1:0]                 undervolt_fault_high_o, // UV 9-16
    output logic [ctp_pkg::NUM_PINS-1:0]               hot_fault_reg_o,        // Hot faults
    output logic [ctp_pkg::NUM_PINS-1:0]               cold_fault_reg_o,       // Cold faults
    output logic [ctp_pkg::NUM_CELLS-1:0]              balance_stop_o,         // Done stops
    output logic [ctp_pkg::NUM_PINS-1:0]               balance_pause_o         // Hot pauses
);
    import ctp_pkg::*;

    // Captured voltage settings
    logic [VLIM_W-1:0]     ov_lim_q, ov_lim_d;     // OV limit copy
    logic [VLIM_W-1:0]     uv_lim_q, uv_lim_d;     // UV limit copy
    logic [VLIM_W-1:0]     done_lim_q, done_lim_d; // Done limit copy
    logic [1:0]            vmode_q, vmode_d;       // Voltage mode copy
    logic [NUM_CELLS-1:0]  cell_act_q, cell_act_d; // Active cells
    logic [NUM_CELLS-1:0]  uv_en_q, uv_en_d;       // UV enabled cells
    logic [CELL_IDX_W-1:0] vlock_q, vlock_d;       // Locked cell copy
    ctp_state_t            vst_q, vst_d;           // Voltage run state
    // Captured temperature settings
    logic [HOT_W-1:0]      hot_lim_q, hot_lim_d;   // Hot limit copy
    logic [COLD_W-1:0]     cold_lim_q, cold_lim_d; // Cold limit copy
    logic [BHOT_W-1:0]     bhot_q, bhot_d;         // Balance hot copy
    logic [COOL_W-1:0]     cool_q, cool_d;         // Hysteresis copy
    logic [1:0]            tmode_q, tmode_d;       // Temp mode copy
    logic [NUM_PINS-1:0]   pin_act_q, pin_act_d;   // Active pins
    logic [PIN_IDX_W-1:0]  tlock_q, tlock_d;       // Locked pin copy
    ctp_state_t            tst_q, tst_d;           // Temp run state
    // Results
    logic [NUM_CELLS-1:0]  ov_q, ov_d;             // OV faults
    logic [NUM_CELLS-1:0]  uv_q, uv_d;             // UV faults
    logic [NUM_PINS-1:0]   hot_q, hot_d;           // Hot faults
    logic [NUM_PINS-1:0]   cold_q, cold_d;         // Cold faults
    logic [NUM_CELLS-1:0]  bstop_q, bstop_d;       // Balance stops
    logic [NUM_PINS-1:0]   bpause_q, bpause_d;     // Balance pauses
    // Scanner outputs
    logic [CELL_IDX_W-1:0] vchan;                  // Current cell
    logic [PIN_IDX_W-1:0]  tchan;                  // Current pin
    logic                  vslot, tslot;           // Slot ends
    logic                  vscan, tscan;           // Scanners running
    // Decoded per-channel values
    logic [NUM_CELLS-1:0]  act_dec;                // Active from top cell
    logic [NUM_PINS-1:0]   pin_dec;                // Active from configs
    logic [VLIM_W-1:0]     vcur;                   // Current cell code
    logic [HOT_W-1:0]      rcur;                   // Current pin ratio

    // Per-cell active decode from highest cell, per-pin config decode
    genvar g;
    generate
        for (g = 0; g < NUM_CELLS; g++) begin : g_cell
            assign act_dec[g] = (CELL_IDX_W'(g) <= highest_cell_field_i);
        end
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            assign pin_dec[g] = (pin_config_i[g*CONF_W +: CONF_W] == CONF_ADC_TEMP);
        end
    endgenerate

    assign vcur = cell_volt_i[vchan*VLIM_W +: VLIM_W];
    assign rcur = pin_ratio_i[tchan*HOT_W +: HOT_W];
    assign vscan = (vst_q == CTP_ST_RUN);
    assign tscan = (tst_q == CTP_ST_RUN);

    // Voltage channel scanner
    ctp_chan_scan #(.IDX_W(CELL_IDX_W), .LAST(NUM_CELLS - 1)) u_vscan (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .run_i      (vscan),
        .lock_i     (vmode_q == CTP_MODE_LOCK),
        .lock_sel_i (vlock_q),
        .chan_o     (vchan),
        .slot_end_o (vslot)
    );

    // Temperature channel scanner
    ctp_chan_scan #(.IDX_W(PIN_IDX_W), .LAST(NUM_PINS - 1)) u_tscan (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .run_i      (tscan),
        .lock_i     (tmode_q == CTP_MODE_LOCK),
        .lock_sel_i (tlock_q),
        .chan_o     (tchan),
        .slot_end_o (tslot)
    );

    // Voltage protector: capture on start, run until stop or shutdown
    always_comb begin
        ov_lim_d   = ov_lim_q;
        uv_lim_d   = uv_lim_q;
        done_lim_d = done_lim_q;
        vmode_d    = vmode_q;
        cell_act_d = cell_act_q;
        uv_en_d    = uv_en_q;
        vlock_d    = vlock_q;
        vst_d      = vst_q;
        if (volt_protect_start_i) begin
            // Snapshot; later edits wait for the next start
            ov_lim_d   = overvoltage_limit_i;
            uv_lim_d   = undervoltage_limit_i;
            done_lim_d = balance_done_limit_i;
            vmode_d    = volt_protect_mode_i;
            cell_act_d = act_dec;
            uv_en_d    = ~{undervolt_mask_high_i, undervolt_mask_low_i};
            vlock_d    = volt_lock_i;
            case (volt_protect_mode_i)
                CTP_MODE_STOP:  vst_d = CTP_ST_IDLE;
                CTP_MODE_TEST:  vst_d = CTP_ST_TEST;
                default:        vst_d = CTP_ST_RUN;
            endcase
        end
        // Sleep does not stop it; only a start in stop mode or shutdown does
        if (shutdown_i) begin
            vst_d = CTP_ST_IDLE;
        end
    end

    // Temperature protector: capture on start, run until stop or shutdown
    always_comb begin
        hot_lim_d  = hot_lim_q;
        cold_lim_d = cold_lim_q;
        bhot_d     = bhot_q;
        cool_d     = cool_q;
        tmode_d    = tmode_q;
        pin_act_d  = pin_act_q;
        tlock_d    = tlock_q;
        tst_d      = tst_q;
        if (temp_protect_start_i) begin
            hot_lim_d  = hot_limit_field_i;
            cold_lim_d = cold_limit_field_i;
            bhot_d     = balance_hot_limit_i;
            cool_d     = cool_off_hyst_i;
            tmode_d    = temp_protect_mode_i;
            pin_act_d  = pin_dec;
            tlock_d    = temp_channel_lock_i;
            case (temp_protect_mode_i)
                CTP_MODE_STOP:  tst_d = CTP_ST_IDLE;
                CTP_MODE_TEST:  tst_d = CTP_ST_TEST;
                default:        tst_d = CTP_ST_RUN;
            endcase
        end
        if (shutdown_i) begin
            tst_d = CTP_ST_IDLE;
        end
    end

    // Detection: one bit per channel, faults sticky until cleared, set wins
    always_comb begin
        ov_d     = fault_clear_i ? '0 : ov_q;
        uv_d     = fault_clear_i ? '0 : uv_q;
        hot_d    = fault_clear_i ? '0 : hot_q;
        cold_d   = fault_clear_i ? '0 : cold_q;
        bstop_d  = bstop_q;
        bpause_d = bpause_q;
        if (volt_protect_start_i) begin
            bstop_d = '0;
        end
        if (temp_protect_start_i) begin
            bpause_d = '0;
        end
        // Voltage checks, only on active cells
        if (vslot && cell_act_q[vchan]) begin
            if (vcur > ov_lim_q) begin
                ov_d[vchan] = 1'b1;
            end
            if (uv_en_q[vchan] && (vcur < uv_lim_q)) begin
                uv_d[vchan] = 1'b1;
            end
            // Done crossing stops balancing only, never a fault
            if (vmode_q == CTP_MODE_ROBIN && vcur < done_lim_q) begin
                bstop_d[vchan] = 1'b1;
            end
        end
        // Temperature checks; self-test state never scans
        if (tslot && pin_act_q[tchan]) begin
            if (!thermistor_reference_i) begin
                hot_d  = hot_d | pin_act_q;
                cold_d = cold_d | pin_act_q;
            end else begin
                if (rcur < hot_lim_q) begin
                    hot_d[tchan] = 1'b1;
                end
                if (rcur > HOT_W'(cold_lim_q)) begin
                    cold_d[tchan] = 1'b1;
                end
                // Balance hot pauses; releases past the cool-off band
                if (tmode_q == CTP_MODE_ROBIN) begin
                    if (rcur < bhot_q) begin
                        bpause_d[tchan] = 1'b1;
                    // One spare bit so limit plus hysteresis cannot wrap
                    end else if ({1'b0, rcur} >= {1'b0, bhot_q} + (BHOT_W + 1)'(cool_q)) begin
                        bpause_d[tchan] = 1'b0;
                    end
                end
            end
        end
    end

    // Register all state
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ov_lim_q   <= '0;
            uv_lim_q   <= '0;
            done_lim_q <= '0;
            vmode_q    <= CTP_MODE_STOP;
            cell_act_q <= '0;
            uv_en_q    <= '0;
            vlock_q    <= '0;
            vst_q      <= CTP_ST_IDLE;
            hot_lim_q  <= '0;
            cold_lim_q <= '0;
            bhot_q     <= '0;
            cool_q     <= '0;
            tmode_q    <= CTP_MODE_STOP;
            pin_act_q  <= '0;
            tlock_q    <= '0;
            tst_q      <= CTP_ST_IDLE;
            ov_q       <= '0;
            uv_q       <= '0;
            hot_q      <= '0;
            cold_q     <= '0;
            bstop_q    <= '0;
            bpause_q   <= '0;
        end else begin
            ov_lim_q   <= ov_lim_d;
            uv_lim_q   <= uv_lim_d;
            done_lim_q <= done_lim_d;
            vmode_q    <= vmode_d;
            cell_act_q <= cell_act_d;
            uv_en_q    <= uv_en_d;
            vlock_q    <= vlock_d;
            vst_q      <= vst_d;
            hot_lim_q  <= hot_lim_d;
            cold_lim_q <= cold_lim_d;
            bhot_q     <= bhot_d;
            cool_q     <= cool_d;
            tmode_q    <= tmode_d;
            pin_act_q  <= pin_act_d;
            tlock_q    <= tlock_d;
            tst_q      <= tst_d;
            ov_q       <= ov_d;
            uv_q       <= uv_d;
            hot_q      <= hot_d;
            cold_q     <= cold_d;
            bstop_q    <= bstop_d;
            bpause_q   <= bpause_d;
        end
    end

    // Status outputs from flip-flops
    assign volt_protect_running_o = (vst_q != CTP_ST_IDLE);
    assign temp_protect_running_o = (tst_q != CTP_ST_IDLE);
    assign overvolt_fault_low_o   = ov_q[HALF_W-1:0];
    assign overvolt_fault_high_o  = ov_q[NUM_CELLS-1:HALF_W];
    assign undervolt_fault_low_o  = uv_q[HALF_W-1:0];
    assign undervolt_fault_high_o = uv_q[NUM_CELLS-1:HALF_W];
    assign hot_fault_reg_o        = hot_q;
    assign cold_fault_reg_o       = cold_q;
    assign balance_stop_o         = bstop_q;
    assign balance_pause_o        = bpause_q;

    // Start in a running mode sets running next cycle
    a_vrun_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (volt_protect_start_i && volt_protect_mode_i != 2'h0 && !shutdown_i)
        |=> volt_protect_running_o) else $error("Voltage run not set");
    a_trun_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (temp_protect_start_i && temp_protect_mode_i == 2'h0)
        |=> !temp_protect_running_o) else $error("Temp stop failed");
    a_vlim_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !volt_protect_start_i |=> $stable(ov_lim_q) && $stable(uv_lim_q))
        else $error("Voltage limits changed without start");
    a_tlim_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !temp_protect_start_i |=> $stable(hot_lim_q) && $stable(pin_act_q))
        else $error("Temp settings changed without start");
    a_inactive_ov: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (vslot && !cell_act_q[vchan] && !ov_q[vchan]) |=> !ov_q[$past(vchan)])
        else $error("Inactive cell flagged");
    a_ov_detect: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (vslot && cell_act_q[vchan] && vcur > ov_lim_q && !fault_clear_i)
        |=> ov_q[$past(vchan)]) else $error("Overvoltage missed");
    a_thermistor_reference_all: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (tslot && pin_act_q[tchan] && !thermistor_reference_i)
        |=> ((hot_q & pin_act_q) == pin_act_q)) else $error("Ref fault missing");
    a_test_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (tst_q == CTP_ST_TEST) |-> !tslot) else $error("Self-test detected");
    a_hot_detect: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (tslot && pin_act_q[tchan] && thermistor_reference_i && rcur < hot_lim_q
         && !fault_clear_i) |=> hot_q[$past(tchan)]) else $error("Hot missed");
    a_done_nofault: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (vslot && vcur < done_lim_q && vcur >= uv_lim_q && !uv_q[vchan])
        |=> !uv_q[$past(vchan)]) else $error("Done flagged as fault");
endmodule // ctp_protect_ctrl

// File: verif/ctp_tap_model.sv
// Behavioural cell taps and thermistor network at fixed test levels
`timescale 1ns/1ns
module ctp_tap_model (
    output logic [127:0] cell_volt_o, // Cell codes
    output logic [39:0]  pin_ratio_o  // Pin ratio codes
);
    // Mid-range taps with a few cells pushed out of the window
    always_comb begin
        cell_volt_o         = {16{8'h80}}; // Healthy level on every tap
        cell_volt_o[23:16]  = 8'hf0;       // Cell 2 high
        cell_volt_o[31:24]  = 8'h10;       // Cell 3 low
        cell_volt_o[39:32]  = 8'h10;       // Cell 4 low, masked
        cell_volt_o[103:96] = 8'hf0;       // Cell 12 high, above top cell
        pin_ratio_o         = {30'h0, 5'h1f, 5'h0}; // Pin 0 hot, pin 1 cold, pin 2 inactive
    end
endmodule // ctp_tap_model

// File: verif/ctp_protect_ctrl_tb_top.sv
// Self-checking bench for the protector control block
`timescale 1ns/1ns
module ctp_protect_ctrl_tb_top;
    import ctp_pkg::*;
    logic         clk_i = 0, rst_n_i = 0, vgo = 0, tgo = 0, clr = 0, tref = 1; // Drives
    logic [1:0]   vmode = 0, tmode = 0;                  // Modes
    logic [7:0]   ovl = 8'hc0, bdone = 8'h00, uvmlo = 8'h10; // Voltage limits, UV mask
    logic [3:0]   topc = 4'h9, vlock = 4'h0;             // Top cell, locked cell
    logic [4:0]   hotl = 5'h10, bhot = 5'h00;            // Hot and balance hot limits
    logic [2:0]   coldl = 3'h7, cool = 3'h0, tlock = 3'h0; // Cold limit, hysteresis, pin
    logic         shut = 0;                              // Shutdown
    logic [15:0]  bstop;                                 // Balance stops
    logic [7:0]   bpause;                                // Balance pauses
    logic [127:0] cv;                                    // Cell codes
    logic [39:0]  pr;                                    // Pin ratios
    logic         vrun, trun;                            // Running flags
    logic [7:0]   ovlo, ovhi, uvlo, uvhi, hotf, coldf;   // Fault registers
    int           bad_count = 0, comparisons = 0, cyc = 0; // Tallies
    ctp_tap_model taps (.cell_volt_o(cv), .pin_ratio_o(pr));
    ctp_protect_ctrl dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .volt_protect_start_i(vgo),
        .volt_protect_mode_i(vmode), .overvoltage_limit_i(ovl), .undervoltage_limit_i(8'h40),
        .balance_done_limit_i(bdone), .highest_cell_field_i(topc),
        .undervolt_mask_low_i(uvmlo), .undervolt_mask_high_i(8'h00), .volt_lock_i(vlock),
        .cell_volt_i(cv), .temp_protect_start_i(tgo), .temp_protect_mode_i(tmode),
        .hot_limit_field_i(hotl), .cold_limit_field_i(coldl), .balance_hot_limit_i(bhot),
        .cool_off_hyst_i(cool), .pin_config_i({18'h0, CONF_ADC_TEMP, CONF_ADC_TEMP}),
        .temp_channel_lock_i(tlock), .thermistor_reference_i(tref), .pin_ratio_i(pr),
        .shutdown_i(shut), .fault_clear_i(clr), .volt_protect_running_o(vrun),
        .temp_protect_running_o(trun), .overvolt_fault_low_o(ovlo),
        .overvolt_fault_high_o(ovhi), .undervolt_fault_low_o(uvlo),
        .undervolt_fault_high_o(uvhi), .hot_fault_reg_o(hotf), .cold_fault_reg_o(coldf),
        .balance_stop_o(bstop), .balance_pause_o(bpause));
    // Clock at 20 MHz
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    // Compare and report
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Clear faults and start the chosen protectors, then wait
    task automatic go(input logic v, input logic t, input logic [1:0] m, input int n);
        @(negedge clk_i);
        vgo = v;
        tgo = t;
        vmode = m;
        tmode = m;
        clr = 1;
        @(negedge clk_i);
        vgo = 0;
        tgo = 0;
        clr = 0;
        repeat (n) @(negedge clk_i);
    endtask
    // Verdict and end of run
    task automatic tally_and_finish;
        if (bad_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    // Main sequence
    initial begin
        repeat (8) @(negedge clk_i);
        rst_n_i = 1;
        go(1, 1, 2'h1, 1);
        check({6'h0, vrun, trun}, 8'h03);
        ovl = 8'h00; // Edit after start must not take effect
        repeat (20) @(negedge clk_i);
        check(ovlo, 8'h04);
        check(ovhi, 8'h00);
        check(uvlo, 8'h08);
        check(uvhi, 8'h00);
        check(hotf, 8'h01);
        check(coldf, 8'h02);
        go(1, 1, 2'h2, 20);
        check({6'h0, vrun, trun}, 8'h03);
        check(ovlo | uvlo | hotf | coldf, 8'h00);
        tref = 0; // Reference left off
        go(0, 1, 2'h1, 12);
        check(hotf, 8'h03);
        check(coldf, 8'h03);
        check({7'h0, vrun}, 8'h01);
        // Robin with new limits, all cells active, no UV mask
        tref = 1;
        ovl = 8'hc0;
        bdone = 8'h90;
        uvmlo = 8'h00;
        topc = 4'hf;
        hotl = 5'h00;
        coldl = 3'h0;
        bhot = 5'h08;
        cool = 3'h4;
        go(1, 1, 2'h1, 20);
        check(ovlo, 8'h04);
        check(ovhi, 8'h10);
        check(uvlo, 8'h18);
        check(bstop[7:0], 8'hfb);
        check(bstop[15:8], 8'hef);
        check(hotf, 8'h00);
        check(coldf, 8'h02);
        check(bpause, 8'h01);
        // Lock on one cell and one pin
        hotl = 5'h10;
        vlock = 4'h3;
        tlock = 3'h1;
        go(1, 1, 2'h3, 4);
        check(ovlo | ovhi | uvhi, 8'h00);
        check(uvlo, 8'h08);
        check(hotf, 8'h00);
        check(coldf, 8'h02);
        // Shutdown stops both protectors
        shut = 1;
        @(negedge clk_i);
        shut = 0;
        @(negedge clk_i);
        check({6'h0, vrun, trun}, 8'h00);
        go(1, 1, 2'h0, 2);
        check({6'h0, vrun, trun}, 8'h00);
        tally_and_finish();
    end
endmodule // ctp_protect_ctrl_tb_top
